// ===== verilog/pmm_defines.svh
// constants of the panel meter min/max and access control block
// assumes inclusion by bare name from the control module
`ifndef PMM_DEFINES_SVH
`define PMM_DEFINES_SVH
// timing figures, in their own units
`define PMM_CLK_NS 20
`define PMM_TICK_NS 100000000
`define PMM_DEBOUNCE_NS 10000000
`define PMM_MSG_TICKS 8'h05
`define PMM_TENTHS_PER_SEC 16'h000a
// user input function codes
`define PMM_FN_W 4
`define PMM_FN_PROGRAM_LOCKOUT_FUNCTION 4'h1
`define PMM_FN_ZERO 4'h2
`define PMM_FN_SEL_MAX 4'h3
`define PMM_FN_RST_MAX 4'h4
`define PMM_FN_RSE_MAX 4'h5
`define PMM_FN_SEL_MIN 4'h6
`define PMM_FN_RST_MIN 4'h7
`define PMM_FN_RSE_MIN 4'h8
`define PMM_FN_RST_HL 4'h9
`define PMM_FN_INTENS 4'ha
`define PMM_FN_PRINT 4'hb
// intensity steps
`define PMM_INT_L0 4'h0
`define PMM_INT_L1 4'h3
`define PMM_INT_L2 4'h8
`define PMM_INT_L3 4'hf
// security codes
`define PMM_CODE_MAX 8'hfa
`define PMM_CODE_UNIV 8'hde
// register offsets
`define PMM_REG_FUNC 8'h00
`define PMM_REG_DLY 8'h04
`define PMM_REG_AZ 8'h08
`define PMM_REG_LOCK 8'h0c
`define PMM_REG_OFFS 8'h10
`define PMM_REG_CODE 8'h14
`define PMM_REG_EXIT 8'h18
`define PMM_REG_MAXV 8'h1c
`define PMM_REG_MINV 8'h20
`define PMM_REG_STAT 8'h24
// fields
`define PMM_DLY_MAX 15:0
`define PMM_DLY_MIN 31:16
`define PMM_AZ_BAND 15:0
`define PMM_AZ_DLY 23:16
`define PMM_AZ_RATE20 24
`define PMM_LK_CODE 7:0
`define PMM_LK_HMAX 8
`define PMM_LK_HMIN 9
`define PMM_LK_HTOT 10
`define PMM_LK_SPVIS 13:12
`define PMM_LK_INT 19:16
`define PMM_VIS_EDIT 2'h1
`define PMM_VIS_RO 2'h0
// reset values
`define PMM_PEAK_RST 16'h0000
`define PMM_CFG_RST 32'h0000_0000
`endif

// ===== verilog/pmm_pkg.sv
// types shared by the panel meter control modules
// assumes the defines header is on the include path
package pmm_pkg;
    typedef enum logic [1:0] {DISP_INPUT, DISP_MAX, DISP_MIN, DISP_TOT} pmm_disp_t;
    typedef enum logic [1:0] {PROG_OFF, PROG_QUICK, PROG_FULL} pmm_prog_t;
endpackage

// ===== verilog/pmm_cond_if.sv
// conditioned input levels and edges between conditioner and control
// assumes one clock domain on both ends
`timescale 1ns/10ps
interface pmm_cond_if #(parameter int N = 5);
    logic [N-1:0] lvl;
    logic [N-1:0] rise;
    modport src(output lvl, output rise);
    modport snk(input lvl, input rise);
endinterface

// ===== verilog/pmm_input_cond.sv
// synchroniser, debouncer and edge detector for key and contact pins
// assumes active-high pins that are asynchronous to clk
`timescale 1ns/10ps
module pmm_input_cond #(
    parameter int N = 5,
    parameter int DEB_CYCLES = 500000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [N-1:0] pins_in,
    pmm_cond_if.src cif
);
    localparam int CW = $clog2(DEB_CYCLES + 1);
    wire [N-1:0] lvl_w;
    wire [N-1:0] rise_w;

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_in
            logic s1_reg;
            logic s2_reg;
            logic st_reg;
            logic rise_reg;
            logic [CW-1:0] cnt_reg;
            // two-stage synchroniser; first stage feeds only the second
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                end else begin
                    s1_reg <= pins_in[gi];
                    s2_reg <= s1_reg;
                end
            end
            // level accepted only after staying put for the whole window
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    st_reg <= 1'b0;
                    cnt_reg <= '0;
                    rise_reg <= 1'b0;
                end else begin
                    rise_reg <= 1'b0;
                    if (s2_reg == st_reg) begin
                        cnt_reg <= '0;
                    end else if (cnt_reg == CW'(DEB_CYCLES - 1)) begin
                        st_reg <= s2_reg;
                        cnt_reg <= '0;
                        rise_reg <= s2_reg; // edge taken from clean level
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
            end
            assign lvl_w[gi] = st_reg;
            assign rise_w[gi] = rise_reg;
        end
    endgenerate

    assign cif.lvl = lvl_w;
    assign cif.rise = rise_w;
endmodule

// ===== verilog/pmm_ctrl.sv
// min/max tracking, intensity, print, lock-out and auto-zero control
// assumes a processed signed reading on clk and a serial port done pulse
`timescale 1ns/10ps
`include "pmm_defines.svh"
//Contract
// - while min-select input held, show minimum; tracking runs regardless.
// - release of min-select returns to live reading; display key overrides.
// - reset-min edge flashes message and loads minimum with displayed reading.
// - reset-select-enable min loads on edge, tracks while held, freezes after.
// - display key overrides only shown content, not the min tracking.
// - joint reset edge flashes message, loads max and min with reading.
// - each intensity edge steps brightness cyclically through 0, 3, 8, 15.
// - key-chosen intensity saved only on programming exit; power-up uses saved.
// - print edge starts a transmission; repeat at end while input held.
// - display key steps displays, skipping hidden ones always.
// - hidden max, min or total displays keep updating underneath.
// - quick mode setpoints are read-only, editable or not shown.
// - code 0..250; nonzero needs matching code or 222 for full access.
// - nonzero code: parameter key gives quick mode first, full after code.
// - inactive lockout input grants full; active with zero code gives quick.
// - intensity shown in quick mode when code exceeds zero.
// - new maximum only after staying above it for the delay.
// - new minimum only after staying below it for the delay.
// - twenty-per-second update rate disables periodic re-zero.
// - reading in band for the delay re-zeroes, restarts timer.
// - zero band disables auto-zero tracking.
// - offset updated after each zero and writable by software.
// - zero command subtracts displayed value from offset.
// - maintained functions follow any active input; momentary fire per edge.
module pmm_ctrl import pmm_pkg::*; #(
    parameter int NUM_UIN = 3,
    parameter int TICK_CYCLES = `PMM_TICK_NS / `PMM_CLK_NS,
    parameter int DEB_CYCLES = `PMM_DEBOUNCE_NS / `PMM_CLK_NS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [NUM_UIN-1:0] user_in,
    input wire logic dsp_key,
    input wire logic parameter_key,
    input wire logic signed [15:0] gross_reading,
    input wire logic tx_done,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    output logic signed [15:0] shown_value,
    output pmm_disp_t disp_sel,
    output logic reset_msg,
    output logic [3:0] intensity,
    output logic print_start,
    output pmm_prog_t prog_mode,
    output logic qp_intensity,
    output logic qp_sp_visible,
    output logic qp_sp_editable,
    output logic rezero_enable,
    output logic nv_save
);
    localparam int NIN = NUM_UIN + 2;
    localparam int TW = $clog2(TICK_CYCLES + 1);

    pmm_cond_if #(.N(NIN)) uc();
    pmm_input_cond #(.N(NIN), .DEB_CYCLES(DEB_CYCLES)) u_cond (
        .clk(clk),
        .rst(rst),
        .pins_in({parameter_key, dsp_key, user_in}),
        .cif(uc)
    );

    logic [31:0] func_reg, dly_reg, az_reg, lock_reg;
    logic signed [15:0] offset_reg, disp_reg, max_reg, min_reg;
    logic [15:0] max_cnt_reg, min_cnt_reg, az_cnt_reg;
    logic [TW-1:0] tick_cnt_reg;
    logic tick_reg, ovr_reg, sel_prev_reg, busy_reg;
    logic [7:0] msg_cnt_reg;
    logic [3:0] saved_int_reg;

    // assignment of a function code to each user input
    function automatic logic [NUM_UIN-1:0] fmask(input logic [3:0] code);
        logic [NUM_UIN-1:0] m;
        m = '0;
        for (int i = 0; i < NUM_UIN; i++) begin
            m[i] = (func_reg[i*`PMM_FN_W +: `PMM_FN_W] == code);
        end
        return m;
    endfunction
    // maintained level and momentary edge over all inputs of one function
    function automatic logic lv(input logic [3:0] code);
        return |(fmask(code) & uc.lvl[NUM_UIN-1:0]);
    endfunction
    function automatic logic ev(input logic [3:0] code);
        return |(fmask(code) & uc.rise[NUM_UIN-1:0]);
    endfunction

    wire dsp_e = uc.rise[NUM_UIN];
    wire par_e = uc.rise[NUM_UIN+1];
    logic sel_min_l, sel_max_l, sel_any, rst_min_e, rst_max_e, hl_e, zero_e;
    logic intens_e, print_e, print_l, program_lockout_function_cfg, program_lockout_function_act, min_frz, max_frz;
    // function decode; a process, so that changes read inside the helpers wake it
    always_comb begin
        sel_min_l = lv(`PMM_FN_SEL_MIN) | lv(`PMM_FN_RSE_MIN);
        sel_max_l = lv(`PMM_FN_SEL_MAX) | lv(`PMM_FN_RSE_MAX);
        sel_any = sel_min_l | sel_max_l;
        rst_min_e = ev(`PMM_FN_RST_MIN) | ev(`PMM_FN_RSE_MIN);
        rst_max_e = ev(`PMM_FN_RST_MAX) | ev(`PMM_FN_RSE_MAX);
        hl_e = ev(`PMM_FN_RST_HL);
        zero_e = ev(`PMM_FN_ZERO);
        intens_e = ev(`PMM_FN_INTENS);
        print_e = ev(`PMM_FN_PRINT);
        print_l = lv(`PMM_FN_PRINT);
        program_lockout_function_cfg = |fmask(`PMM_FN_PROGRAM_LOCKOUT_FUNCTION);
        program_lockout_function_act = lv(`PMM_FN_PROGRAM_LOCKOUT_FUNCTION);
        // freeze only when the enable style is assigned and released
        min_frz = (|fmask(`PMM_FN_RSE_MIN)) & ~lv(`PMM_FN_RSE_MIN);
        max_frz = (|fmask(`PMM_FN_RSE_MAX)) & ~lv(`PMM_FN_RSE_MAX);
    end
    wire wr_func = wr_stb & (addr == `PMM_REG_FUNC);
    wire wr_lock = wr_stb & (addr == `PMM_REG_LOCK);
    wire wr_offs = wr_stb & (addr == `PMM_REG_OFFS);
    wire wr_code = wr_stb & (addr == `PMM_REG_CODE);
    wire wr_exit = wr_stb & (addr == `PMM_REG_EXIT);
    wire [7:0] code_cfg = lock_reg[`PMM_LK_CODE];
    wire [15:0] az_band = az_reg[`PMM_AZ_BAND];
    wire [15:0] az_lim = 16'(az_reg[`PMM_AZ_DLY]) * `PMM_TENTHS_PER_SEC;
    wire [15:0] disp_abs = disp_reg[15] ? 16'(-disp_reg) : disp_reg;
    wire az_en = (az_band != 16'h0000) & ~az_reg[`PMM_AZ_RATE20];
    wire az_in = az_en & (disp_abs <= az_band);
    wire az_fire = az_in & tick_reg & (az_cnt_reg >= az_lim);

    // tenth-second time base shared by all delay timers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg == TW'(TICK_CYCLES - 1)) begin
            tick_cnt_reg <= '0;
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
            tick_reg <= 1'b0;
        end
    end

    // configuration registers; security code clamps to its top value
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            func_reg <= `PMM_CFG_RST;
            dly_reg <= `PMM_CFG_RST;
            az_reg <= `PMM_CFG_RST;
            lock_reg <= `PMM_CFG_RST;
        end else if (wr_stb) begin
            if (wr_func) func_reg <= wdata;
            if (addr == `PMM_REG_DLY) dly_reg <= wdata;
            if (addr == `PMM_REG_AZ) az_reg <= wdata;
            if (wr_lock) begin
                lock_reg <= wdata;
                if (wdata[`PMM_LK_CODE] > `PMM_CODE_MAX) begin
                    lock_reg[`PMM_LK_CODE] <= `PMM_CODE_MAX;
                end
            end
        end
    end

    // relative reading: gross plus offset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) disp_reg <= `PMM_PEAK_RST;
        else disp_reg <= 16'(gross_reading + offset_reg);
    end

    // offset: software write beats tare and auto-zero, which make the same subtraction
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            offset_reg <= `PMM_PEAK_RST;
        end else if (wr_offs) begin
            offset_reg <= wdata[15:0];
        end else if (zero_e || az_fire) begin
            offset_reg <= 16'(offset_reg - disp_reg);
        end
    end

    // auto-zero timer restarts when out of band or after firing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) az_cnt_reg <= '0;
        else if (!az_in || az_fire) az_cnt_reg <= '0;
        else if (tick_reg) az_cnt_reg <= az_cnt_reg + 1'b1;
    end

    // maximum tracker; runs even when hidden or not shown
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            max_reg <= `PMM_PEAK_RST;
            max_cnt_reg <= '0;
        end else if (rst_max_e || hl_e) begin
            max_reg <= disp_reg;
            max_cnt_reg <= '0;
        end else if (!max_frz && disp_reg > max_reg) begin
            if (max_cnt_reg >= dly_reg[`PMM_DLY_MAX]) begin
                max_reg <= disp_reg;
                max_cnt_reg <= '0;
            end else if (tick_reg) begin
                max_cnt_reg <= max_cnt_reg + 1'b1;
            end
        end else begin
            max_cnt_reg <= '0;
        end
    end

    // minimum tracker; display key never touches it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            min_reg <= `PMM_PEAK_RST;
            min_cnt_reg <= '0;
        end else if (rst_min_e || hl_e) begin
            min_reg <= disp_reg;
            min_cnt_reg <= '0;
        end else if (!min_frz && disp_reg < min_reg) begin
            if (min_cnt_reg >= dly_reg[`PMM_DLY_MIN]) begin
                min_reg <= disp_reg;
                min_cnt_reg <= '0;
            end else if (tick_reg) begin
                min_cnt_reg <= min_cnt_reg + 1'b1;
            end
        end else begin
            min_cnt_reg <= '0;
        end
    end

    // next display in the key cycle, hidden ones skipped
    function automatic pmm_disp_t next_disp(input pmm_disp_t cur);
        logic [1:0] c;
        c = cur;
        for (int k = 0; k < 4; k++) begin
            c = c + 2'h1;
            if (!((c == DISP_MAX && lock_reg[`PMM_LK_HMAX]) ||
                  (c == DISP_MIN && lock_reg[`PMM_LK_HMIN]) ||
                  (c == DISP_TOT && lock_reg[`PMM_LK_HTOT]))) break;
        end
        return pmm_disp_t'(c);
    endfunction

    // display selection; key press overrides a held select input
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            disp_sel <= DISP_INPUT;
            ovr_reg <= 1'b0;
            sel_prev_reg <= 1'b0;
        end else begin
            sel_prev_reg <= sel_any;
            if (dsp_e && prog_mode == PROG_OFF) begin
                disp_sel <= next_disp(disp_sel);
                ovr_reg <= sel_any;
            end else if (sel_min_l && !ovr_reg) begin
                disp_sel <= DISP_MIN;
            end else if (sel_max_l && !ovr_reg) begin
                disp_sel <= DISP_MAX;
            end else if (sel_prev_reg && !sel_any) begin
                disp_sel <= DISP_INPUT;
                ovr_reg <= 1'b0;
            end
        end
    end

    // shown value follows the selection; total is muxed downstream
    always_ff @(posedge clk or posedge rst) begin
        if (rst) shown_value <= `PMM_PEAK_RST;
        else if (disp_sel == DISP_MIN) shown_value <= min_reg;
        else if (disp_sel == DISP_MAX) shown_value <= max_reg;
        else shown_value <= disp_reg;
    end

    // reset message flashes for a few ticks after any reset or tare
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            msg_cnt_reg <= '0;
            reset_msg <= 1'b0;
        end else begin
            if (rst_min_e || rst_max_e || hl_e || zero_e) begin
                msg_cnt_reg <= `PMM_MSG_TICKS;
            end else if (tick_reg && msg_cnt_reg != 8'h00) begin
                msg_cnt_reg <= msg_cnt_reg - 8'h01;
            end
            reset_msg <= (msg_cnt_reg != 8'h00);
        end
    end

    // intensity; only a programming exit commits it to storage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            intensity <= `PMM_INT_L3;
            saved_int_reg <= `PMM_INT_L3;
            nv_save <= 1'b0;
        end else begin
            nv_save <= wr_exit && prog_mode != PROG_OFF;
            if (wr_lock) begin
                intensity <= wdata[`PMM_LK_INT]; // restored level at power-up
                saved_int_reg <= wdata[`PMM_LK_INT];
            end else if (intens_e) begin
                case (intensity)
                    `PMM_INT_L0: intensity <= `PMM_INT_L1;
                    `PMM_INT_L1: intensity <= `PMM_INT_L2;
                    `PMM_INT_L2: intensity <= `PMM_INT_L3;
                    default: intensity <= `PMM_INT_L0;
                endcase
            end
            if (wr_exit && prog_mode != PROG_OFF) saved_int_reg <= intensity;
        end
    end

    // programming access decision on the parameter key
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prog_mode <= PROG_OFF;
            qp_intensity <= 1'b0;
        end else if (wr_exit) begin
            prog_mode <= PROG_OFF;
        end else if (par_e && prog_mode == PROG_OFF) begin
            qp_intensity <= (code_cfg != 8'h00);
            if (program_lockout_function_cfg && !program_lockout_function_act) prog_mode <= PROG_FULL;
            else if (code_cfg == 8'h00 && !program_lockout_function_act) prog_mode <= PROG_FULL;
            else prog_mode <= PROG_QUICK;
        end else if (wr_code && prog_mode == PROG_QUICK && code_cfg != 8'h00) begin
            if (wdata[7:0] == code_cfg || wdata[7:0] == `PMM_CODE_UNIV) begin
                prog_mode <= PROG_FULL;
            end
        end
    end

    // quick-mode setpoint visibility, three-way
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            qp_sp_visible <= 1'b0;
            qp_sp_editable <= 1'b0;
            rezero_enable <= 1'b0;
        end else begin
            qp_sp_visible <= lock_reg[`PMM_LK_SPVIS] == `PMM_VIS_RO ||
                             lock_reg[`PMM_LK_SPVIS] == `PMM_VIS_EDIT;
            qp_sp_editable <= lock_reg[`PMM_LK_SPVIS] == `PMM_VIS_EDIT;
            rezero_enable <= ~az_reg[`PMM_AZ_RATE20];
        end
    end

    // print requests; serial port reports the end of each block
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            print_start <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            print_start <= (print_e && !busy_reg && !print_start) ||
                           (tx_done && busy_reg && print_l);
            if (print_start) busy_reg <= 1'b1;
            else if (tx_done) busy_reg <= 1'b0;
        end
    end

    // register reads: data only in the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= '0;
        end else if (!rd_stb) begin
            rdata <= '0;
        end else begin
            case (addr)
                `PMM_REG_FUNC: rdata <= func_reg;
                `PMM_REG_DLY: rdata <= dly_reg;
                `PMM_REG_AZ: rdata <= az_reg;
                `PMM_REG_LOCK: rdata <= {lock_reg[31:20], saved_int_reg, lock_reg[15:0]};
                `PMM_REG_OFFS: rdata <= 32'(unsigned'(offset_reg));
                `PMM_REG_MAXV: rdata <= 32'(unsigned'(max_reg));
                `PMM_REG_MINV: rdata <= 32'(unsigned'(min_reg));
                `PMM_REG_STAT: rdata <= {22'h0, busy_reg, reset_msg, intensity,
                                         prog_mode, disp_sel};
                default: rdata <= '0;
            endcase
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence tare_s;
        zero_e && !wr_offs;
    endsequence
    sequence print_go_s;
        print_e && !busy_reg && !print_start;
    endsequence
    min_show_a: assert property (!dsp_e && sel_min_l && !ovr_reg |=> disp_sel == DISP_MIN)
        else $error("minimum not shown while select held");
    min_load_a: assert property (rst_min_e |=> min_reg == $past(disp_reg))
        else $error("minimum not loaded on reset edge");
    hl_load_a: assert property (hl_e |=> max_reg == $past(disp_reg) && min_reg == max_reg)
        else $error("joint reset did not load both peaks");
    intens_step_a: assert property (intens_e && !wr_lock && intensity == `PMM_INT_L2
        |=> intensity == `PMM_INT_L3 ##0 reset_msg == $past(reset_msg))
        else $error("intensity step wrong");
    print_start_a: assert property (print_go_s |=> print_start ##1 busy_reg)
        else $error("print not started");
    print_rep_a: assert property (tx_done && busy_reg && print_l |=> print_start)
        else $error("held print did not repeat");
    hide_skip_a: assert property (dsp_e && prog_mode == PROG_OFF && lock_reg[`PMM_LK_HMAX]
        |=> disp_sel != DISP_MAX)
        else $error("hidden display shown");
    code_gate_a: assert property (wr_code && prog_mode == PROG_QUICK &&
        wdata[7:0] != code_cfg && wdata[7:0] != `PMM_CODE_UNIV |=> prog_mode == PROG_QUICK)
        else $error("wrong code granted access");
    tare_offs_a: assert property (tare_s |=> offset_reg == 16'($past(offset_reg) - $past(disp_reg)))
        else $error("tare offset wrong");
endmodule

// ===== sim/pmm_panel.sv
// front panel keys and user contacts, with contact chatter
// assumes the bench sets want just after a rising edge
`timescale 1ns/10ps
module pmm_panel (
    input wire logic clk,
    input wire logic [4:0] want,
    output logic [4:0] pins
);
    logic [4:0] last_reg = 5'h00;
    logic [4:0] pin_reg = 5'h00;
    logic [1:0] bnc_reg = 2'h0;
    // a changed contact chatters three cycles, so the debouncer earns its keep
    always_ff @(posedge clk) begin
        if (want != last_reg && bnc_reg == 2'h0) begin
            bnc_reg <= 2'h3;
        end else if (bnc_reg != 2'h0) begin
            bnc_reg <= bnc_reg - 2'h1;
        end
        last_reg <= (bnc_reg == 2'h1) ? want : last_reg;
        pin_reg <= (bnc_reg != 2'h0) ? (pin_reg ^ (want ^ last_reg)) : last_reg;
    end
    assign pins = pin_reg;
endmodule

// ===== sim/tb.sv
// self-checking bench for the panel meter control block
// assumes short tick and debounce counts so the run stays brief
`timescale 1ns/10ps
module tb import pmm_pkg::*;;
    typedef struct {logic [4:0] w; logic [3:0] inten; pmm_disp_t disp;} pmm_row_t;
    logic clk = 1'b0, rst = 1'b1, tx_done = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
    logic [4:0] want = 5'h00;
    logic [4:0] pins;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic signed [15:0] gross = 16'sh0123;
    pmm_disp_t disp_sel;
    pmm_prog_t prog_mode;
    logic reset_msg, print_start, qp_int, nv_save, qp_vis, qp_edit, rezero;
    logic [15:0] shown;
    logic [3:0] intensity;
    int failures = 0, compares = 0;
    // in0 steps intensity, in1 selects minimum; last row wraps to the lowest step
    pmm_row_t rows [9] = '{'{5'h01, 4'h0, DISP_INPUT}, '{5'h00, 4'h0, DISP_INPUT},
        '{5'h01, 4'h3, DISP_INPUT}, '{5'h02, 4'h3, DISP_MIN}, '{5'h03, 4'h8, DISP_MIN},
        '{5'h00, 4'h8, DISP_INPUT}, '{5'h01, 4'hf, DISP_INPUT}, '{5'h00, 4'hf, DISP_INPUT},
        '{5'h01, 4'h0, DISP_INPUT}};
    always #10 clk = ~clk;
    pmm_panel panel (.clk(clk), .want(want), .pins(pins));
    pmm_ctrl #(.TICK_CYCLES(10), .DEB_CYCLES(4)) dut (.clk(clk), .rst(rst),
        .user_in(pins[2:0]), .dsp_key(pins[3]), .parameter_key(pins[4]),
        .gross_reading(gross), .tx_done(tx_done), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .shown_value(shown),
        .disp_sel(disp_sel), .reset_msg(reset_msg), .intensity(intensity),
        .print_start(print_start), .prog_mode(prog_mode), .qp_intensity(qp_int),
        .qp_sp_visible(qp_vis), .qp_sp_editable(qp_edit), .rezero_enable(rezero),
        .nv_save(nv_save));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (failures == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ends at the falling edge so registered results have landed
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    // chatter plus debounce plus sync fits well inside twenty cycles
    task automatic press(input logic [4:0] w);
        @(posedge clk);
        want <= w;
        repeat (20) @(negedge clk);
    endtask
    task automatic await_print();
        int n;
        n = 0;
        while (print_start !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check(intensity, 4'hf);
        wr(8'h00, 32'h0000_076a);
        foreach (rows[i]) begin
            press(rows[i].w);
            check(intensity, rows[i].inten);
            check(disp_sel, rows[i].disp);
        end
        wr(8'h04, 32'h0003_ffff);
        press(5'h04);
        check(reset_msg, 1'b1);
        rd(8'h20);
        check(d, 32'h0000_0123);
        @(posedge clk);
        gross <= 16'sh0100;
        rd(8'h20);
        check(d, 32'h0000_0123);
        repeat (60) @(negedge clk);
        rd(8'h20);
        check(d, 32'h0000_0100);
        wr(8'h00, 32'h0000_000b);
        press(5'h00);
        @(posedge clk);
        want <= 5'h01;
        await_print();
        check(print_start, 1'b1);
        @(posedge clk);
        tx_done <= 1'b1;
        @(posedge clk);
        tx_done <= 1'b0;
        await_print();
        check(print_start, 1'b1);
        wr(8'h0c, 32'h0000_0105);
        press(5'h08);
        press(5'h00);
        check(disp_sel, DISP_MIN);
        check(shown, 16'h0100);
        press(5'h10);
        press(5'h00);
        check(prog_mode, PROG_QUICK);
        check(qp_int, 1'b1);
        check(qp_edit, 1'b0);
        check(rezero, 1'b1);
        wr(8'h14, 32'h0000_0007);
        check(prog_mode, PROG_QUICK);
        wr(8'h14, 32'h0000_00de);
        check(prog_mode, PROG_FULL);
        wr(8'h18, 32'h0);
        check(nv_save, 1'b1);
        wr(8'h00, 32'h0000_0100);
        press(5'h10);
        press(5'h00);
        check(prog_mode, PROG_FULL);
        wr(8'h18, 32'h0);
        // direct offset write, then a tare takes the reading off it
        wr(8'h10, 32'h0000_0020);
        rd(8'h10);
        check(d, 32'h0000_0020);
        wr(8'h00, 32'h0000_0092);
        press(5'h01);
        rd(8'h10);
        check(d, 32'h0000_ff00);
        press(5'h02);
        rd(8'h1c);
        check(d, 32'h0);
        // a reading of 5 sits inside a band of 16 for one second
        wr(8'h08, 32'h0001_0010);
        @(posedge clk);
        gross <= 16'sh0105;
        repeat (150) @(negedge clk);
        rd(8'h10);
        check(d, 32'h0000_fefb);
        wr(8'h08, 32'h0101_0010);
        @(posedge clk);
        gross <= 16'sh010a;
        repeat (150) @(negedge clk);
        rd(8'h10);
        check(d, 32'h0000_fefb);
        check(rezero, 1'b0);
        wr(8'h0c, 32'h0000_1000);
        @(negedge clk);
        check(qp_vis, 1'b1);
        check(qp_edit, 1'b1);
        wr(8'h0c, 32'h0000_2000);
        @(negedge clk);
        check(qp_vis, 1'b0);
        // minimum shown, access off, lowest step, print still busy
        rd(8'h24);
        check(d, 32'h0000_0202);
        rd(8'h30);
        check(d, 32'h0);
        tally_and_finish();
    end
endmodule
